/* File: logic/srp_pkg.sv */
// Package of constants for the stop recovery power control block
package srp_pkg;
    localparam logic [11:0] SRP_ADDR_POWER_CONTROL  = 12'hF80;
    localparam logic [11:0] SRP_ADDR_STATUS         = 12'hF81;
    localparam logic [7:0]  SRP_POWER_CONTROL_RESET = 8'h88;
    localparam logic [7:0]  SRP_POWER_CONTROL_MASK  = 8'hFF;
    localparam int          SRP_BIT_BOD_DISABLE     = 4;
    localparam int          SRP_BIT_COMP_DISABLE    = 1;
    localparam int          SRP_BIT_STS_STOPPED     = 0;
    localparam int          SRP_BIT_STS_HOLD        = 1;
    localparam int          SRP_BIT_STS_RECOVERED   = 2;
    localparam int          SRP_BIT_STS_BOD_ON      = 3;
    localparam int          SRP_BIT_STS_COMP_ON     = 4;
    // Hold counts in oscillator cycles
    localparam int          SRP_HOLD_CYC_NO_XTAL    = 66;
    localparam int          SRP_HOLD_CYC_XTAL       = 5000;
    localparam int          SRP_CNT_W               = 13;
    typedef enum logic [2:0] {
        SRP_RUN     = 3'b001,
        SRP_STOPPED = 3'b010,
        SRP_HOLD    = 3'b100
    } srp_state_e;
endpackage : srp_pkg

/* File: logic/srp_stop_recovery.sv */
// Stop state entry, recovery reset hold and power control register
`timescale 1ns/1ps
//
// Contract
// - Executing the stop instruction puts the device into the stop state.
// - Recovery holds processor reset 66 cycles without crystal, 5000 with crystal.
// - Recovery changes only reset cause and oscillator control registers.
// - After recovery the internal oscillator is enabled and chosen as clock.
// - Power control register resets only on power-on reset.
// - Bit 4 disables the brown-out detector unless the always-on option is set.
// - In stop state the detector is off whenever always-on option is clear.
// - Bit 1 set disables the comparator; clear enables it.
module srp_stop_recovery
    import srp_pkg::*;
#(
    parameter int HOLD_CYC_XTAL = SRP_HOLD_CYC_XTAL
) (
    // Clock and resets
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    input  wire logic        por_n,
    // Processor side
    input  wire logic        stop_exec,
    input  wire logic        wake_event,
    input  wire logic        xtal_enabled,
    output logic             cpu_reset_hold,
    output logic             stop_mode,
    // Recovery side effects on neighbour registers
    output logic             recovery_done,
    output logic             osc_force_ipo,
    // Option and analog controls
    input  wire logic        brownout_always_on_option,
    output logic             brownout_detector_enable,
    output logic             comparator_enable,
    // Register port
    input  wire logic [11:0] reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic [7:0]       reg_rdata
);
    localparam logic [SRP_CNT_W-1:0] TC_NO_XTAL = SRP_CNT_W'(SRP_HOLD_CYC_NO_XTAL - 1);
    localparam logic [SRP_CNT_W-1:0] TC_XTAL    = SRP_CNT_W'(HOLD_CYC_XTAL - 1);

    srp_state_e           state;
    srp_state_e           next_state;
    logic [SRP_CNT_W-1:0] hold_cnt;
    logic [SRP_CNT_W-1:0] hold_tc;
    logic [7:0]           power_control_register;
    logic                 bod_ok;

    // Oscillator clock is the system clock here
    always_comb begin
        next_state = state;
        unique case (state)
            SRP_RUN:     if (stop_exec) next_state = SRP_STOPPED;
            SRP_STOPPED: if (wake_event) next_state = SRP_HOLD;
            SRP_HOLD:    if (hold_cnt == hold_tc) next_state = SRP_RUN;
            default:     next_state = SRP_RUN;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            state <= SRP_RUN;
        end else begin
            state <= next_state;
        end
    end

    // Terminal count latched at wake from the crystal state
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            hold_cnt <= '0;
            hold_tc  <= TC_NO_XTAL;
        end else if (state == SRP_STOPPED) begin
            hold_cnt <= '0;
            hold_tc  <= xtal_enabled ? TC_XTAL : TC_NO_XTAL;
        end else if (state == SRP_HOLD) begin
            hold_cnt <= hold_cnt + SRP_CNT_W'(1);
        end
    end

    assign cpu_reset_hold = (state == SRP_HOLD);
    assign stop_mode      = (state == SRP_STOPPED);

    // Pulse at end of hold; only reset-cause and oscillator registers consume it
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            recovery_done <= 1'b0;
            osc_force_ipo <= 1'b0;
        end else begin
            recovery_done <= (state == SRP_HOLD) && (next_state == SRP_RUN);
            osc_force_ipo <= (state == SRP_HOLD) && (next_state == SRP_RUN);
        end
    end

    // Only power-on reset loads SRP_POWER_CONTROL_RESET (8'h88) into this register; writes load reg_wdata
    always_ff @(posedge ref_clk) begin
        if (!por_n) begin
            power_control_register <= SRP_POWER_CONTROL_RESET;
        end else if (reg_write && reg_addr == SRP_ADDR_POWER_CONTROL) begin
            power_control_register <= reg_wdata & SRP_POWER_CONTROL_MASK;
        end
    end

    always_comb begin
        if (brownout_always_on_option) begin
            bod_ok = 1'b1;
        end else if (state == SRP_STOPPED) begin
            bod_ok = 1'b0;
        end else begin
            bod_ok = !power_control_register[SRP_BIT_BOD_DISABLE];
        end
    end

    assign brownout_detector_enable = bod_ok;
    assign comparator_enable = !power_control_register[SRP_BIT_COMP_DISABLE];

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_read) begin
            unique case (reg_addr)
                SRP_ADDR_POWER_CONTROL: reg_rdata <= power_control_register;
                SRP_ADDR_STATUS: begin
                    reg_rdata <= 8'h00;
                    reg_rdata[SRP_BIT_STS_STOPPED]   <= stop_mode;
                    reg_rdata[SRP_BIT_STS_HOLD]      <= cpu_reset_hold;
                    reg_rdata[SRP_BIT_STS_RECOVERED] <= recovery_done;
                    reg_rdata[SRP_BIT_STS_BOD_ON]    <= bod_ok;
                    reg_rdata[SRP_BIT_STS_COMP_ON]   <= comparator_enable;
                end
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end
endmodule : srp_stop_recovery

/* File: testbench/srp_stop_recovery_monitor.sv */
// Port checker for the stop recovery block
`timescale 1ns/1ps
module srp_stop_recovery_monitor (
    input wire logic ref_clk, reset_n, stop_exec, wake_event, stop_mode,
    input wire logic cpu_reset_hold, recovery_done, osc_force_ipo,
    input wire logic brownout_always_on_option, brownout_detector_enable,
    input wire logic comparator_enable
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    property p_enter; stop_exec && !stop_mode && !cpu_reset_hold |=> stop_mode; endproperty
    a_enter: assert property (p_enter) else $error("stop not entered");
    property p_stay; stop_mode && !wake_event |=> stop_mode; endproperty
    a_stay: assert property (p_stay) else $error("stop left early");
    property p_start; stop_mode && wake_event |=> cpu_reset_hold; endproperty
    a_start: assert property (p_start) else $error("hold late");
    property p_len; $rose(cpu_reset_hold) |-> cpu_reset_hold [*8]; endproperty
    a_len: assert property (p_len) else $error("hold short");
    property p_done; $fell(cpu_reset_hold) |-> recovery_done && osc_force_ipo; endproperty
    a_done: assert property (p_done) else $error("no ipo select");
    property p_pulse; recovery_done |-> $past(cpu_reset_hold) && !cpu_reset_hold; endproperty
    a_pulse: assert property (p_pulse) else $error("stray done");
    property p_keep; cpu_reset_hold |-> $stable(comparator_enable); endproperty
    a_keep: assert property (p_keep) else $error("register changed");
    property p_bstop;
        stop_mode && !brownout_always_on_option |-> !brownout_detector_enable;
    endproperty
    a_bstop: assert property (p_bstop) else $error("detector on in stop");
    property p_bao; brownout_always_on_option |-> brownout_detector_enable; endproperty
    a_bao: assert property (p_bao) else $error("detector off");
    c_wake: cover property (stop_mode && wake_event);
    c_done: cover property (recovery_done);
    c_stop: cover property (stop_mode && !brownout_always_on_option);
endmodule : srp_stop_recovery_monitor
bind srp_stop_recovery srp_stop_recovery_monitor srp_stop_recovery_monitor_i (.*);

/* File: testbench/srp_cpu_model.sv */
// Processor core model issuing stop and wake
`timescale 1ns/1ps
module srp_cpu_model (
    input  wire logic ref_clk,
    input  wire logic do_stop,
    input  wire logic do_wake,
    input  wire logic cpu_reset_hold,
    output logic      stop_exec,
    output logic      wake_event
);
    initial {stop_exec, wake_event} = 2'b00;
    // Recovery code keeps the forced oscillator choice, so no reprogramming is issued
    // No instruction runs while held in reset
    always @(posedge ref_clk) begin
        stop_exec  <= do_stop && !cpu_reset_hold;
        wake_event <= do_wake;
    end
endmodule : srp_cpu_model

/* File: testbench/srp_stop_recovery_tb.sv */
// Testbench for the stop recovery block
`timescale 1ns/1ps
`define CK(n, e, a) begin check_count++; if ((a) !== (e)) begin n_fail++; \
    $display("BAD %s exp %h got %h", n, e, a); end end
module srp_stop_recovery_tb import srp_pkg::*;;
    logic ref_clk = 1'b0, reset_n, por_n, do_stop, do_wake, xtal_enabled;
    logic stop_exec, wake_event, cpu_reset_hold, stop_mode, recovery_done, osc_force_ipo;
    logic brownout_always_on_option, brownout_detector_enable, comparator_enable;
    logic [11:0] reg_addr;
    logic [7:0]  reg_wdata, reg_rdata;
    logic        reg_write, reg_read;
    int n_fail, check_count;
    always #5 ref_clk = ~ref_clk;
    srp_stop_recovery #(.HOLD_CYC_XTAL(10)) srp_stop_recovery_i (.*);
    srp_cpu_model srp_cpu_model_i (.*);
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        reg_addr <= a; reg_wdata <= d; reg_write <= 1'b1;
        @(posedge ref_clk) reg_write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        reg_addr <= a; reg_read <= 1'b1;
        @(posedge ref_clk) reg_read <= 1'b0;
        #1 `CK("rdata", e, reg_rdata)
    endtask : rd
    task automatic rec(input logic x, input int n);
        int c;
        c = 0;
        xtal_enabled <= x; do_stop <= 1'b1;
        @(posedge ref_clk) do_stop <= 1'b0;
        repeat (3) @(posedge ref_clk);
        #1 `CK("stop", 1'b1, stop_mode)
        `CK("bod", 1'b0, brownout_detector_enable)
        do_wake <= 1'b1;
        @(posedge ref_clk) do_wake <= 1'b0;
        for (int i = 0; i < 9000 && (c == 0 || cpu_reset_hold); i++) begin
            @(posedge ref_clk) #1 if (cpu_reset_hold) c++;
        end
        `CK("hold", n, c)
        `CK("done", 2'b11, {recovery_done, osc_force_ipo})
    endtask : rec
    task automatic end_sim;
        $display("checks %0d fails %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_sim
    initial begin
        {reset_n, por_n, do_stop, do_wake, xtal_enabled, reg_write, reg_read} = '0;
        {reg_addr, reg_wdata, brownout_always_on_option} = '0;
        n_fail = 0; check_count = 0;
        repeat (12) @(posedge ref_clk);
        {reset_n, por_n} <= 2'b11;
        @(posedge ref_clk);
        rd(SRP_ADDR_POWER_CONTROL, SRP_POWER_CONTROL_RESET);
        wr(SRP_ADDR_POWER_CONTROL, 8'h1A);
        #1 `CK("cmp", 1'b0, comparator_enable)
        `CK("bod", 1'b0, brownout_detector_enable)
        @(posedge ref_clk) brownout_always_on_option <= 1'b1;
        #1 `CK("bod", 1'b1, brownout_detector_enable)
        @(posedge ref_clk) {brownout_always_on_option, reset_n} <= 2'b00;
        @(posedge ref_clk) reset_n <= 1'b1;
        @(posedge ref_clk);
        rd(SRP_ADDR_POWER_CONTROL, 8'h1A);
        wr(SRP_ADDR_POWER_CONTROL, 8'h08);
        #1 `CK("cmp", 1'b1, comparator_enable)
        `CK("bod", 1'b1, brownout_detector_enable)
        rd(SRP_ADDR_STATUS, 8'h18);
        rec(1'b0, SRP_HOLD_CYC_NO_XTAL);
        rd(SRP_ADDR_POWER_CONTROL, 8'h08);
        rec(1'b1, 10);
        rd(12'h123, 8'h00);
        end_sim();
    end
endmodule : srp_stop_recovery_tb
